// ---- rtl/icaf_filter.sv ----
// Functional notes
// - tx disable blocks tx ring and sends
// - tx disable clears transmitter running at start
// - rx disable rejects all frames, no ring
// - rx disable clears receiver running at start
// - no transmit chaining during loopback
// - hash mask is four 16-bit words
// - first bit one means group address
// - crc all 48 bits, keep top six
// - index picks mask bit, accept or reject
// - broadcast accepted whenever receiver runs and rx disable is clear, bypasses hash
// - external loopback hashing needs tx crc disable
// - ring length field is power of two
// - ring reserved bits read zero
// - tx crc disable gives crc to receiver
module icaf_filter
  import icaf_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire icaf_da_t    da_in,
  input  wire logic        tx_req_in,
  output icaf_verdict_t    verdict_out,
  output logic             tx_ring_en_out,
  output logic             tx_start_out,
  output logic             tx_append_crc_out,
  output logic             tx_chain_en_out,
  output logic             rx_ring_en_out,
  output logic             rx_crc_check_out,
  output logic [7:0]       rx_ring_entries_out,
  output logic [23:0]      rx_ring_base_out,
  output logic             transmitter_running_out,
  output logic             receiver_running_out
);

  typedef enum logic [1:0] {ST_IDLE, ST_HASH, ST_DONE} icaf_state_t;

  logic [15:0]   mode;
  logic [47:0]   station;
  logic [63:0]   hash_mask;
  logic [31:0]   rx_ring;
  logic [1:0]    ctrl_pulse;
  logic [31:0]   status_word;
  logic          crc_busy;
  logic          crc_done;
  logic [5:0]    crc_index;
  icaf_state_t   state_r;
  icaf_state_t   state_nxt;
  icaf_verdict_t verdict_r;
  icaf_verdict_t verdict_nxt;
  logic          inited_r;
  logic          tx_run_r;
  logic          rx_run_r;
  logic          tx_start_r;
  logic [47:0]   da_r;
  logic          da_crc_r;
  logic          tx_append_r;
  logic          tx_chain_r;
  logic          rx_crc_chk_r;
  logic [7:0]    ring_entries_r;
  logic [23:0]   ring_base_r;
  logic          tx_ring_en_r;
  logic          rx_ring_en_r;

  wire tx_dis     = mode[MODE_TX_DIS_BIT];
  wire rx_dis     = mode[MODE_RX_DIS_BIT];
  wire loop_on    = mode[MODE_LOOP_BIT];
  wire ext_loop   = loop_on && mode[MODE_EXTLB_BIT];
  wire tx_crc_dis = mode[MODE_TX_CRC_BIT];
  wire init_cmd   = ctrl_pulse[CTRL_INIT_BIT];
  wire strt_cmd   = ctrl_pulse[CTRL_STRT_BIT];
  wire is_group   = da_r[0];
  wire is_bcast   = &da_r;
  wire hash_ok    = !ext_loop || tx_crc_dis;
  wire da_take    = da_in.valid && (state_r == ST_IDLE);

  icaf_apb_regs u_regs (
    .sys_clk_in     (sys_clk_in),
    .sys_rst_in     (sys_rst_in),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .status_in      (status_word),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .mode_out       (mode),
    .station_out    (station),
    .hash_mask_out  (hash_mask),
    .rx_ring_out    (rx_ring),
    .ctrl_pulse_out (ctrl_pulse)
  );

  icaf_hash_crc u_crc (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .start_in   (da_take),
    .addr_in    (da_in.addr),
    .busy_out   (crc_busy),
    .done_out   (crc_done),
    .index_out  (crc_index)
  );

  assign status_word = {26'h0, crc_busy, verdict_r.accept, rx_run_r, tx_run_r,
                        1'b0, inited_r};

  // address filter sequencing
  always_comb
  begin
    state_nxt   = state_r;
    verdict_nxt = verdict_r;
    verdict_nxt.done = 1'b0;
    unique case (state_r)
      ST_IDLE:
        if (da_in.valid)
          state_nxt = ST_HASH;
      ST_HASH:
        if (crc_done)
        begin
          state_nxt          = ST_IDLE;
          verdict_nxt.done   = 1'b1;
          verdict_nxt.group  = is_group;
          verdict_nxt.index  = crc_index;
          if (rx_dis || !rx_run_r)
            verdict_nxt.accept = 1'b0;
          else if (is_bcast)
            verdict_nxt.accept = 1'b1;
          else if (is_group)
            verdict_nxt.accept = hash_ok && hash_mask[crc_index];
          else
            verdict_nxt.accept = (da_r == station);
        end
      ST_DONE:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_r   <= ST_IDLE;
      verdict_r <= '0;
      da_r      <= 48'h0;
      da_crc_r  <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      verdict_r <= verdict_nxt;
      if (da_take)
      begin
        da_r     <= da_in.addr;
        da_crc_r <= da_in.crc_given;
      end
    end
  end

  // running flags follow init and start commands
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      inited_r   <= 1'b0;
      tx_run_r   <= 1'b0;
      rx_run_r   <= 1'b0;
      tx_start_r <= 1'b0;
    end
    else
    begin
      if (init_cmd)
      begin
        inited_r <= 1'b1;
        tx_run_r <= 1'b0;
        rx_run_r <= 1'b0;
      end
      else if (strt_cmd && inited_r)
      begin
        tx_run_r <= !tx_dis;
        rx_run_r <= !rx_dis;
      end
      tx_start_r <= tx_req_in && tx_run_r && !tx_dis;
    end
  end

  // decoded controls registered so every pin leaves a flop
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      tx_append_r    <= 1'b1;
      tx_chain_r     <= 1'b1;
      rx_crc_chk_r   <= 1'b1;
      ring_entries_r <= 8'h01;
      ring_base_r    <= 24'h00_0000;
      tx_ring_en_r   <= 1'b0;
      rx_ring_en_r   <= 1'b0;
    end
    else
    begin
      tx_append_r    <= !tx_crc_dis;
      tx_chain_r     <= !loop_on;
      rx_crc_chk_r   <= tx_crc_dis || !loop_on;
      ring_entries_r <= 8'h01 << rx_ring[RING_LEN_LSB +: 3];
      ring_base_r    <= {rx_ring[23:3], 3'b000};
      tx_ring_en_r   <= tx_run_r && !tx_dis;
      rx_ring_en_r   <= rx_run_r && !rx_dis;
    end
  end

  assign verdict_out             = verdict_r;
  assign tx_ring_en_out          = tx_ring_en_r;
  assign tx_start_out            = tx_start_r;
  assign tx_append_crc_out       = tx_append_r;
  assign tx_chain_en_out         = tx_chain_r;
  assign rx_ring_en_out          = rx_ring_en_r;
  assign rx_crc_check_out        = rx_crc_chk_r;
  assign rx_ring_entries_out     = ring_entries_r;
  assign rx_ring_base_out        = ring_base_r;
  assign transmitter_running_out = tx_run_r;
  assign receiver_running_out    = rx_run_r;

  a_bcast_accept: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (state_r == ST_HASH && crc_done && is_bcast && rx_run_r && !rx_dis)
    |=> verdict_r.accept) else $error("broadcast rejected");

  a_rx_disable: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (state_r == ST_HASH && crc_done && rx_dis) |=> !verdict_r.accept)
    else $error("frame accepted with receiver disabled");

  a_tx_disable: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    tx_dis |-> ##1 !tx_start_out) else $error("transmit while disabled");

  a_tx_run_clear: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (strt_cmd && inited_r && !init_cmd && tx_dis) |=> !transmitter_running_out)
    else $error("tx running not cleared");

  a_rx_run_clear: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (strt_cmd && inited_r && !init_cmd && rx_dis) |=> !receiver_running_out)
    else $error("rx running not cleared");

  a_hash_select: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (state_r == ST_HASH && crc_done && is_group && !is_bcast && rx_run_r
     && !rx_dis && hash_ok)
    |=> verdict_r.accept == $past(hash_mask[crc_index]))
    else $error("hash mask bit not honoured");

  a_hash_latency: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (state_r == ST_IDLE && da_in.valid) |-> ##[1:50] verdict_r.done)
    else $error("hash verdict late");

  a_loop_chain: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    loop_on |=> !tx_chain_en_out) else $error("chaining in loopback");

  a_ring_res: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    rx_ring[28:24] == 5'h00 && rx_ring[2:0] == 3'h0)
    else $error("ring reserved bits set");

  a_ext_hash: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (state_r == ST_HASH && crc_done && is_group && !is_bcast && ext_loop
     && !tx_crc_dis) |=> !verdict_r.accept)
    else $error("hash in ext loopback without crc disable");

  a_group_flag: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (state_r == ST_HASH && crc_done)
    |=> verdict_r.group == $past(da_r[0]))
    else $error("group flag not from first bit");

  a_ring_length: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $onehot(rx_ring_entries_out) && rx_ring_entries_out[$past(rx_ring[31:29])])
    else $error("ring entry count not a power of two");

  a_crc_share: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    tx_crc_dis |=> !tx_append_crc_out && rx_crc_check_out)
    else $error("crc not handed to receiver");

  a_init_clear: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    init_cmd |=> !transmitter_running_out && !receiver_running_out)
    else $error("init left a running flag set");

  a_tx_ring_off: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    tx_dis |=> !tx_ring_en_out)
    else $error("tx ring enabled while disabled");

  a_rx_ring_off: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    rx_dis |=> !rx_ring_en_out)
    else $error("rx ring enabled while disabled");

  a_station_match: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (state_r == ST_HASH && crc_done && !is_group && rx_run_r && !rx_dis)
    |=> verdict_r.accept == $past(da_r == station))
    else $error("unicast filter mismatch");

endmodule

// ---- rtl/icaf_pkg.sv ----
package icaf_pkg;

  // register byte offsets on the apb slave
  localparam logic [7:0] OFS_MODE      = 8'h00;
  localparam logic [7:0] OFS_STA_LO    = 8'h04;
  localparam logic [7:0] OFS_STA_HI    = 8'h08;
  localparam logic [7:0] OFS_HASH_0    = 8'h0c;
  localparam logic [7:0] OFS_HASH_1    = 8'h10;
  localparam logic [7:0] OFS_HASH_2    = 8'h14;
  localparam logic [7:0] OFS_HASH_3    = 8'h18;
  localparam logic [7:0] OFS_RX_RING   = 8'h1c;
  localparam logic [7:0] OFS_CTRL      = 8'h20;
  localparam logic [7:0] OFS_STATUS    = 8'h24;

  // operating mode word fields
  localparam int MODE_RX_DIS_BIT  = 0;
  localparam int MODE_TX_DIS_BIT  = 1;
  localparam int MODE_TX_CRC_BIT  = 3;
  localparam int MODE_LOOP_BIT    = 2;
  localparam int MODE_EXTLB_BIT   = 6;

  // control register fields
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_STRT_BIT = 1;

  // receive ring pointer fields
  localparam int RING_LEN_LSB  = 29;
  localparam logic [31:0] RING_WR_MASK = 32'he0ff_fff8;

  localparam logic [15:0] MODE_RST   = 16'h0000;
  localparam logic [31:0] CRC_PRESET = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY_R = 32'hedb8_8320;
  localparam int          ADDR_BITS  = 48;
  localparam logic [5:0]  ADDR_CNT_LAST = 6'h2f;

  typedef struct packed {
    logic        valid;
    logic [47:0] addr;
    logic        crc_given;
  } icaf_da_t;

  typedef struct packed {
    logic       done;
    logic       accept;
    logic       group;
    logic [5:0] index;
  } icaf_verdict_t;

endpackage

// ---- rtl/icaf_hash_crc.sv ----
module icaf_hash_crc
  import icaf_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        start_in,
  input  wire logic [47:0] addr_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [5:0]       index_out
);

  logic [31:0] crc_r;
  logic [47:0] sh_r;
  logic [5:0]  cnt_r;
  logic        busy_r;
  logic        done_r;
  logic [5:0]  idx_r;
  logic        fb;
  logic [31:0] crc_nxt;
  logic [31:0] crc_msb;

  // lsb-first serial crc, bit order of transmission
  assign fb      = crc_r[0] ^ sh_r[0];
  assign crc_nxt = (crc_r >> 1) ^ (fb ? CRC_POLY_R : 32'h0000_0000);
  assign crc_msb = crc_nxt;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      crc_r  <= CRC_PRESET;
      sh_r   <= 48'h0;
      cnt_r  <= 6'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      idx_r  <= 6'h0;
    end
    else
    begin
      done_r <= 1'b0;
      if (start_in && !busy_r)
      begin
        crc_r  <= CRC_PRESET;
        sh_r   <= addr_in;
        cnt_r  <= 6'h0;
        busy_r <= 1'b1;
      end
      else if (busy_r)
      begin
        crc_r <= crc_nxt;
        sh_r  <= sh_r >> 1;
        cnt_r <= cnt_r + 6'h1;
        if (cnt_r == ADDR_CNT_LAST)
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          // six most significant crc bits, reflected register holds msb in bit 0
          idx_r  <= {crc_msb[0], crc_msb[1], crc_msb[2],
                     crc_msb[3], crc_msb[4], crc_msb[5]};
        end
      end
    end
  end

  assign busy_out  = busy_r;
  assign done_out  = done_r;
  assign index_out = idx_r;

endmodule

// ---- rtl/icaf_apb_regs.sv ----
module icaf_apb_regs
  import icaf_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] status_in,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [15:0]      mode_out,
  output logic [47:0]      station_out,
  output logic [63:0]      hash_mask_out,
  output logic [31:0]      rx_ring_out,
  output logic [1:0]       ctrl_pulse_out
);

  logic [15:0] mode_r;
  logic [47:0] sta_r;
  logic [63:0] hash_r;
  logic [31:0] ring_r;
  logic [31:0] rdata_r;
  logic        err_r;
  logic [1:0]  pulse_r;
  logic        acc;
  logic        wr;
  logic        hit;
  logic [31:0] rd_mux;

  assign acc = psel && penable;
  assign wr  = acc && pwrite && pready;
  assign hit = (paddr <= OFS_STATUS) && (paddr[1:0] == 2'b00);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_MODE:    rd_mux = {16'h0000, mode_r};
      OFS_STA_LO:  rd_mux = sta_r[31:0];
      OFS_STA_HI:  rd_mux = {16'h0000, sta_r[47:32]};
      OFS_HASH_0:  rd_mux = {16'h0000, hash_r[15:0]};
      OFS_HASH_1:  rd_mux = {16'h0000, hash_r[31:16]};
      OFS_HASH_2:  rd_mux = {16'h0000, hash_r[47:32]};
      OFS_HASH_3:  rd_mux = {16'h0000, hash_r[63:48]};
      OFS_RX_RING: rd_mux = ring_r;
      OFS_STATUS:  rd_mux = status_in;
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // single wait state: answer one cycle after access phase begins
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      mode_r  <= MODE_RST;
      sta_r   <= 48'h0;
      hash_r  <= 64'h0;
      ring_r  <= 32'h0000_0000;
      rdata_r <= 32'h0000_0000;
      err_r   <= 1'b0;
      pulse_r <= 2'b00;
    end
    else
    begin
      pulse_r <= 2'b00;
      if (acc && !pready)
      begin
        rdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
        err_r   <= !hit;
      end
      else
      begin
        err_r <= 1'b0;
      end
      // writes land on the edge that completes the transfer
      if (wr)
      begin
        unique case (paddr)
          OFS_MODE:    mode_r         <= pwdata[15:0];
          OFS_STA_LO:  sta_r[31:0]    <= pwdata;
          OFS_STA_HI:  sta_r[47:32]   <= pwdata[15:0];
          OFS_HASH_0:  hash_r[15:0]   <= pwdata[15:0];
          OFS_HASH_1:  hash_r[31:16]  <= pwdata[15:0];
          OFS_HASH_2:  hash_r[47:32]  <= pwdata[15:0];
          OFS_HASH_3:  hash_r[63:48]  <= pwdata[15:0];
          OFS_RX_RING: ring_r         <= pwdata & RING_WR_MASK;
          OFS_CTRL:    pulse_r        <= pwdata[1:0];
          default:     ;
        endcase
      end
    end
  end

  logic rdy_r;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      rdy_r <= 1'b0;
    else
      rdy_r <= acc && !rdy_r;
  end

  assign pready         = rdy_r;
  assign pslverr        = err_r;
  assign prdata         = rdata_r;
  assign mode_out       = mode_r;
  assign station_out    = sta_r;
  assign hash_mask_out  = hash_r;
  assign rx_ring_out    = ring_r;
  assign ctrl_pulse_out = pulse_r;

endmodule

// ---- testbench/icaf_host_model.sv ----
module icaf_host_model
  import icaf_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // loopback receive buffers are sized for descriptor lookahead
  localparam int LOOP_BUF_BYTES = 32;

  logic timed_out;

  initial
  begin
    timed_out = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    timed_out = timed_out | (n >= 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask

  task automatic load_station(input logic [47:0] a);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, OFS_STA_LO, {a[31:1], 1'b0}, rd, er);
    apb(1'b1, OFS_STA_HI, {16'h0000, a[47:32]}, rd, er);
  endtask

  task automatic load_ring(input logic [2:0] len, input logic [20:0] base);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, OFS_RX_RING, {len, 5'h00, base, 3'h0}, rd, er);
  endtask
endmodule

// ---- testbench/tb_init_config_address_filter.sv ----
module tb_init_config_address_filter
  import icaf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic          sys_clk_in, sys_rst_in, psel, penable, pwrite, pready, pslverr, tx_req_in;
  logic [7:0]    paddr, rx_ring_entries_out;
  logic [31:0]   pwdata, prdata;
  logic [23:0]   rx_ring_base_out;
  logic          tx_ring_en_out, tx_start_out, tx_append_crc_out, tx_chain_en_out;
  logic          rx_ring_en_out, rx_crc_check_out, transmitter_running_out;
  logic          receiver_running_out, started;
  icaf_da_t      da_in;
  icaf_verdict_t verdict_out;
  logic [15:0]   mode_m;
  logic [47:0]   sta_m, a;
  logic [63:0]   mask_m;
  logic [20:0]   b;
  int            failures, cmp_count, seed;
  localparam logic [111:0] MODE_SET = {16'h004c, 16'h0044, 16'h0008, 16'h0003, 16'h0002,
                                       16'h0001, 16'h0000};

  icaf_filter dut_u (.sys_clk_in, .sys_rst_in, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .da_in, .tx_req_in, .verdict_out, .tx_ring_en_out,
    .tx_start_out, .tx_append_crc_out, .tx_chain_en_out, .rx_ring_en_out, .rx_crc_check_out,
    .rx_ring_entries_out, .rx_ring_base_out, .transmitter_running_out, .receiver_running_out);

  icaf_host_model host_u (.sys_clk_in, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
    .paddr, .pwdata);

  always #4 sys_clk_in = ~sys_clk_in;

  task automatic stop_test;
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic guard(input logic hung);
    if (hung)
    begin
      failures++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    host_u.apb(1'b1, ad, d, rd, er);
    guard(host_u.timed_out);
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp, input logic exp_er);
    logic [31:0] rd;
    logic        er;
    host_u.apb(1'b0, ad, 32'h0000_0000, rd, er);
    guard(host_u.timed_out);
    chk({er, rd}, {exp_er, exp});
  endtask

  // reflected crc, first received bit first
  function automatic logic [5:0] hash_of(input logic [47:0] x);
    logic [31:0] c;
    c = CRC_PRESET;
    for (int i = 0; i < 48; i++)
      c = (c >> 1) ^ ((c[0] ^ x[i]) ? CRC_POLY_R : 32'h0000_0000);
    // index msb is the x^31 term, which the reflected register holds in bit 0
    return {c[0], c[1], c[2], c[3], c[4], c[5]};
  endfunction

  function automatic logic acc_of(input logic [47:0] x);
    if (!started || mode_m[MODE_RX_DIS_BIT])
      return 1'b0;
    if (x == 48'hffff_ffff_ffff)
      return 1'b1;
    if (x[0])
      return mask_m[hash_of(x)] && !(mode_m[MODE_LOOP_BIT] && mode_m[MODE_EXTLB_BIT]
             && !mode_m[MODE_TX_CRC_BIT]);
    return x == sta_m;
  endfunction

  task automatic probe(input logic [47:0] x);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    da_in <= '{1'b1, x, 1'b0};
    @(posedge sys_clk_in);
    da_in <= '{1'b0, ~x, 1'b0};
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (verdict_out.done !== 1'b1 && n < 80);
    guard(n >= 80);
    chk(verdict_out.accept, acc_of(x));
    if (started && !mode_m[MODE_RX_DIS_BIT] && x[0] && x != 48'hffff_ffff_ffff)
      chk({verdict_out.group, verdict_out.index}, {1'b1, hash_of(x)});
  endtask

  task automatic cfg(input logic [15:0] m, input logic [63:0] k);
    logic seen;
    mode_m = m;
    mask_m = k;
    wr(OFS_MODE, {16'h0000, m});
    for (int i = 0; i < 4; i++)
      wr(OFS_HASH_0 + 8'(4 * i), {16'h0000, k[16 * i +: 16]});
    wr(OFS_CTRL, 32'h0000_0001);
    started = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    chk({transmitter_running_out, receiver_running_out}, 2'b00);
    probe(48'({$random(seed), $random(seed)}) | 48'h1);
    wr(OFS_CTRL, 32'h0000_0002);
    started = 1'b1;
    @(posedge sys_clk_in);
    rd_chk(OFS_MODE, {16'h0000, m}, 1'b0);
    rd_chk(OFS_STATUS, {26'h0, 2'b00, !m[MODE_RX_DIS_BIT], !m[MODE_TX_DIS_BIT], 2'b01},
           1'b0);
    chk({transmitter_running_out, tx_ring_en_out}, {2{!m[MODE_TX_DIS_BIT]}});
    chk({receiver_running_out, rx_ring_en_out}, {2{!m[MODE_RX_DIS_BIT]}});
    chk({tx_append_crc_out, rx_crc_check_out}, {!m[3], m[3] | !m[2]});
    chk(tx_chain_en_out, !m[MODE_LOOP_BIT]);
    seen = 1'b0;
    tx_req_in <= 1'b1;
    repeat (3)
    begin
      @(posedge sys_clk_in);
      seen = seen | tx_start_out;
    end
    tx_req_in <= 1'b0;
    chk(seen, !m[MODE_TX_DIS_BIT]);
  endtask

  initial
  begin
    seed       = 35;
    failures   = 0;
    cmp_count  = 0;
    started    = 1'b0;
    mode_m     = 16'h0000;
    mask_m     = 64'h0;
    sys_clk_in = 1'b0;
    sys_rst_in = 1'b1;
    tx_req_in  = 1'b0;
    da_in      = '0;
    repeat (5) @(posedge sys_clk_in);
    chk({tx_append_crc_out, tx_chain_en_out, rx_crc_check_out, rx_ring_entries_out},
        {3'b111, 8'h01});
    sys_rst_in <= 1'b0;
    for (int l = 0; l < 8; l++)
    begin
      b = 21'($random(seed));
      host_u.load_ring(3'(l), b);
      repeat (2) @(posedge sys_clk_in);
      chk({rx_ring_entries_out, rx_ring_base_out}, {8'(1 << l), b, 3'h0});
      rd_chk(OFS_RX_RING, {3'(l), 5'h00, b, 3'h0}, 1'b0);
    end
    wr(OFS_RX_RING, 32'hffff_ffff);
    rd_chk(OFS_RX_RING, 32'he0ff_fff8, 1'b0);
    rd_chk(8'h40, 32'h0000_0000, 1'b1);
    rd_chk(8'h06, 32'h0000_0000, 1'b1);
    sta_m = 48'({$random(seed), $random(seed)}) & 48'hffff_ffff_fffe;
    host_u.load_station(sta_m);
    rd_chk(OFS_STA_LO, sta_m[31:0], 1'b0);
    cfg(16'h0000, 64'h0);
    probe(48'hffff_ffff_ffff);
    probe(48'h0000_0000_0101);
    for (int j = 0; j < 7; j++)
    begin
      cfg(MODE_SET[16 * j +: 16], 64'({$random(seed), $random(seed)}));
      probe(48'hffff_ffff_ffff);
      probe(sta_m);
      probe(sta_m ^ 48'h0000_0100_0000);
      repeat (6)
        probe(48'({$random(seed), $random(seed)}) | 48'h1);
    end
    stop_test();
  end
endmodule
